// *** hw/fci_pkg.sv ***
// Purpose: Constants for the host-side flash command controller
// Assumes: 250 MHz system clock, byte-wide flash with 19 address lines
// Notes:   Command codes and unlock addresses of the flash command set
package fci_pkg;
  localparam int          ADDR_W         = 19;
  localparam int          DATA_W         = 8;
  localparam int          CLK_MHZ        = 250;
  // Unlock cycle addresses and data
  localparam logic [18:0] UNLOCK1_ADDR   = 19'h00555;
  localparam logic [18:0] UNLOCK2_ADDR   = 19'h002AA;
  localparam logic [7:0]  UNLOCK1_DATA   = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
  // Command codes
  localparam logic [7:0]  CMD_RESET      = 8'hF0;
  localparam logic [7:0]  CMD_IDENT      = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]  CMD_BYPASS     = 8'h20;
  localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  CMD_BLK_ERASE  = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0]  CMD_RESUME     = 8'h30;
  localparam logic [7:0]  CMD_BYP_EXIT2  = 8'h00;
  // Identification read addresses (A1,A0)
  localparam logic [18:0] ID_MAKER_ADDR  = 19'h00000;
  localparam logic [18:0] ID_PART_ADDR   = 19'h00001;
  localparam logic [18:0] ID_PROT_ADDR   = 19'h00002;
  localparam int          BLK_SEL_LSB    = 16;
  // Bus cycle timing in ns and derived cycles
  localparam int          T_SETUP_NS     = 40;
  localparam int          T_PULSE_NS     = 80;
  localparam int          T_ABORT_NS     = 10000;
  localparam int          T_BLK_GAP_NS   = 50000;
  localparam int          SETUP_CYC      = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          PULSE_CYC      = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int          ABORT_CYC      = (T_ABORT_NS * CLK_MHZ + 999) / 1000;
  localparam int          BLK_GAP_CYC    = (T_BLK_GAP_NS * CLK_MHZ) / 1000;
  // Operation codes requested by the user
  typedef enum logic [3:0] {
    OP_RESET1   = 4'h0,
    OP_RESET3   = 4'h1,
    OP_IDENT    = 4'h2,
    OP_PROGRAM  = 4'h3,
    OP_BYPASS   = 4'h4,
    OP_BYP_PROG = 4'h5,
    OP_BYP_EXIT = 4'h6,
    OP_CHIP_ERS = 4'h7,
    OP_BLK_ERS  = 4'h8,
    OP_BLK_ADD  = 4'h9,
    OP_SUSPEND  = 4'hA,
    OP_RESUME   = 4'hB,
    OP_READ     = 4'hC
  } fci_op_t;
endpackage

// *** hw/fci_seq_rom.sv ***
// Purpose: Write-cycle sequence table for each command
// Assumes: Index is op and step; output registered
// Notes:   Last entry flagged; target entries use the user address, and the user data except for block erase
`timescale 1ns/1ps
module fci_seq_rom (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [3:0]  op_i,
  input  wire logic [2:0]  step_i,
  output logic      [18:0] addr_o,
  output logic      [7:0]  data_o,
  output logic             use_user_o,
  output logic             last_o
);
  logic [18:0] addr_next;
  logic [7:0]  data_next;
  logic        user_next;
  logic        last_next;

  function automatic logic [28:0] unl(input logic [2:0] s, input logic [7:0] d,
                                      input logic lst);
    case (s)
      3'd0:    unl = {fci_pkg::UNLOCK1_ADDR, fci_pkg::UNLOCK1_DATA, 1'b0, 1'b0};
      3'd1:    unl = {fci_pkg::UNLOCK2_ADDR, fci_pkg::UNLOCK2_DATA, 1'b0, 1'b0};
      default: unl = {fci_pkg::UNLOCK1_ADDR, d, 1'b0, lst};
    endcase
  endfunction

  always_comb begin
    logic [28:0] e;
    e = '0;
    case (fci_pkg::fci_op_t'(op_i))
      fci_pkg::OP_RESET1:   e = {19'h0, fci_pkg::CMD_RESET, 1'b0, 1'b1};
      fci_pkg::OP_RESET3:   e = unl(step_i, fci_pkg::CMD_RESET, 1'b1);
      fci_pkg::OP_IDENT:    e = unl(step_i, fci_pkg::CMD_IDENT, 1'b1);
      fci_pkg::OP_BYPASS:   e = unl(step_i, fci_pkg::CMD_BYPASS, 1'b1);
      fci_pkg::OP_PROGRAM: begin
        if (step_i == 3'd3) e = {19'h0, 8'h00, 1'b1, 1'b1};
        else e = unl(step_i, fci_pkg::CMD_PROGRAM, 1'b0);
      end
      fci_pkg::OP_BYP_PROG: begin
        if (step_i == 3'd0) e = {19'h0, fci_pkg::CMD_PROGRAM, 1'b0, 1'b0};
        else e = {19'h0, 8'h00, 1'b1, 1'b1};
      end
      fci_pkg::OP_BYP_EXIT: begin
        if (step_i == 3'd0) e = {19'h0, fci_pkg::CMD_IDENT, 1'b0, 1'b0};
        else e = {19'h0, fci_pkg::CMD_BYP_EXIT2, 1'b0, 1'b1};
      end
      fci_pkg::OP_CHIP_ERS, fci_pkg::OP_BLK_ERS: begin
        if (step_i < 3'd2) e = unl(step_i, 8'h00, 1'b0);
        else if (step_i == 3'd2)
          e = unl(step_i, fci_pkg::CMD_ERASE_SET, 1'b0);
        else if (step_i < 3'd5) e = unl(step_i - 3'd3, 8'h00, 1'b0);
        else if (op_i == 4'(fci_pkg::OP_CHIP_ERS))
          e = unl(3'd2, fci_pkg::CMD_CHIP_ERASE, 1'b1);
        else e = {19'h0, fci_pkg::CMD_BLK_ERASE, 1'b1, 1'b1};
      end
      fci_pkg::OP_BLK_ADD:  e = {19'h0, fci_pkg::CMD_BLK_ERASE, 1'b1, 1'b1};
      fci_pkg::OP_SUSPEND:  e = {19'h0, fci_pkg::CMD_SUSPEND, 1'b0, 1'b1};
      fci_pkg::OP_RESUME:   e = {19'h0, fci_pkg::CMD_RESUME, 1'b0, 1'b1};
      default:              e = {19'h0, 8'h00, 1'b0, 1'b1};
    endcase
    addr_next = e[28:10];
    data_next = e[9:2];
    user_next = e[1];
    last_next = e[0];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_o     <= '0;
      data_o     <= '0;
      use_user_o <= 1'b0;
      last_o     <= 1'b0;
    end else begin
      addr_o     <= addr_next;
      data_o     <= data_next;
      use_user_o <= user_next;
      last_o     <= last_next;
    end
  end
endmodule

// *** hw/fci_host.sv ***
// Purpose: Host controller driving a byte-wide flash command interface
// Assumes: Flash pins are asynchronous; data inputs are synchronised
// Notes:   One user operation at a time; reads are plain bus reads
`timescale 1ns/1ps
module fci_host #(
  parameter int ABORT_CYC = fci_pkg::ABORT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        req_i,
  input  wire logic [3:0]  op_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        id_level_i,
  output logic             ready_o,
  output logic             done_o,
  output logic      [7:0]  rdata_o,
  output logic      [18:0] byte_address_o,
  output logic      [7:0]  data_lines_o,
  output logic             data_lines_oe_o,
  input  wire logic [7:0]  data_lines_i,
  output logic             chip_en_n_o,
  output logic             out_en_n_o,
  output logic             wr_en_n_o,
  output logic             identification_level_o,
  output logic             bypass_o
);
  // A zero abort wait would let reads start inside the abort period
  if (ABORT_CYC < 1) begin : g_abort_chk
    $error("ABORT_CYC must be at least one");
  end

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_LOAD  = 6'b000010,
    S_SETUP = 6'b000100,
    S_PULSE = 6'b001000,
    S_HOLD  = 6'b010000,
    S_WAIT  = 6'b100000
  } fci_state_t;

  localparam int CW = $clog2(fci_pkg::BLK_GAP_CYC + ABORT_CYC + 2);

  fci_state_t    state_reg;
  logic [2:0]    step_reg;
  logic [3:0]    op_reg;
  logic [18:0]   uaddr_reg;
  logic [7:0]    udata_reg;
  logic [CW-1:0] cnt_reg;
  logic          bypass_reg;
  logic          is_read_reg;
  logic [7:0]    sync1_reg;
  logic [7:0]    sync2_reg;
  logic [18:0]   rom_addr;
  logic [7:0]    rom_data;
  logic          rom_user;
  logic          rom_last;

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction

  fci_seq_rom u_rom (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .op_i       (op_reg),
    .step_i     (step_reg),
    .addr_o     (rom_addr),
    .data_o     (rom_data),
    .use_user_o (rom_user),
    .last_o     (rom_last)
  );

  assign ready_o = (state_reg == S_IDLE);
  assign bypass_o = bypass_reg;

  // Data lines from the flash cross an asynchronous boundary
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= data_lines_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Sequencer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg   <= S_IDLE;
      step_reg    <= '0;
      op_reg      <= 4'(fci_pkg::OP_READ);
      uaddr_reg   <= '0;
      udata_reg   <= '0;
      cnt_reg     <= '0;
      is_read_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (req_i) begin
            op_reg      <= op_i;
            uaddr_reg   <= addr_i;
            udata_reg   <= data_i;
            step_reg    <= '0;
            is_read_reg <= (op_i == 4'(fci_pkg::OP_READ));
            state_reg   <= S_LOAD;
          end
        end
        S_LOAD: begin
          cnt_reg   <= cyc(fci_pkg::SETUP_CYC);
          state_reg <= S_SETUP;
        end
        S_SETUP: begin
          if (cnt_reg > cyc(1)) cnt_reg <= cnt_reg - cyc(1);
          else begin
            cnt_reg   <= is_read_reg ? cyc(fci_pkg::PULSE_CYC + 2)
                                     : cyc(fci_pkg::PULSE_CYC);
            state_reg <= S_PULSE;
          end
        end
        S_PULSE: begin
          // Flash latches data on the rising write enable edge
          if (cnt_reg > cyc(1)) cnt_reg <= cnt_reg - cyc(1);
          else begin
            cnt_reg   <= cyc(fci_pkg::SETUP_CYC);
            state_reg <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt_reg > cyc(1)) cnt_reg <= cnt_reg - cyc(1);
          else if (is_read_reg || rom_last) begin
            state_reg <= S_WAIT;
            // Reset may need the abort time before valid reads
            if (op_reg == 4'(fci_pkg::OP_RESET1) ||
                op_reg == 4'(fci_pkg::OP_RESET3))
              cnt_reg <= cyc(ABORT_CYC);
            else
              cnt_reg <= cyc(1);
          end else begin
            step_reg  <= step_reg + 3'd1;
            state_reg <= S_LOAD;
          end
        end
        S_WAIT: begin
          if (cnt_reg > cyc(1)) cnt_reg <= cnt_reg - cyc(1);
          else state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Pins; address compare by flash uses only low bits
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_address_o  <= '0;
      data_lines_o    <= '0;
      data_lines_oe_o <= 1'b0;
      chip_en_n_o     <= 1'b1;
      out_en_n_o      <= 1'b1;
      wr_en_n_o       <= 1'b1;
    end else begin
      chip_en_n_o <= 1'b1;
      out_en_n_o  <= 1'b1;
      wr_en_n_o   <= 1'b1;
      if (state_reg == S_SETUP || state_reg == S_PULSE) begin
        chip_en_n_o <= 1'b0;
        if (is_read_reg) begin
          // ID, protection and status reads are plain reads
          byte_address_o  <= uaddr_reg;
          data_lines_oe_o <= 1'b0;
          out_en_n_o      <= 1'b0;
        end else begin
          // Target or fixed cycle from the table
          byte_address_o  <= rom_user ? uaddr_reg : rom_addr;
          data_lines_o    <= rom_user && op_reg != 4'(fci_pkg::OP_BLK_ERS)
                             && op_reg != 4'(fci_pkg::OP_BLK_ADD)
                             ? udata_reg : rom_data;
          data_lines_oe_o <= 1'b1;
          wr_en_n_o       <= (state_reg == S_PULSE) ? 1'b0 : 1'b1;
        end
      end else if (state_reg == S_HOLD) begin
        data_lines_oe_o <= ~is_read_reg;
      end else begin
        data_lines_oe_o <= 1'b0;
      end
    end
  end

  // Identification level pin held high only while requested
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) identification_level_o <= 1'b0;
    else identification_level_o <= id_level_i;
  end

  // Tracks bypass mode; reset keeps it, exit clears it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) bypass_reg <= 1'b0;
    else if (state_reg == S_HOLD && rom_last && !is_read_reg &&
             cnt_reg == cyc(1)) begin
      if (op_reg == 4'(fci_pkg::OP_BYPASS)) bypass_reg <= 1'b1;
      else if (op_reg == 4'(fci_pkg::OP_BYP_EXIT)) bypass_reg <= 1'b0;
    end
  end

  // Read data sampled late in the pulse, after the synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= (state_reg == S_WAIT) && (cnt_reg <= cyc(1));
      if (is_read_reg && state_reg == S_PULSE && cnt_reg == cyc(1))
        rdata_o <= sync2_reg;
    end
  end
endmodule

// *** sim/fci_host_assertions.sv ***
// Purpose: Port checks for the flash host controller
// Assumes: One clock, async active-low reset
// Notes:   Bound into every fci_host instance
`timescale 1ns/1ps
module fci_host_chk #(
  parameter int ABORT_CYC = 5
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        req_i,
  input wire logic        ready_o,
  input wire logic        done_o,
  input wire logic [18:0] byte_address_o,
  input wire logic [7:0]  data_lines_o,
  input wire logic        data_lines_oe_o,
  input wire logic        chip_en_n_o,
  input wire logic        out_en_n_o,
  input wire logic        wr_en_n_o,
  input wire logic        bypass_o
);
  int we_cnt_reg;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) we_cnt_reg <= 0;
    else we_cnt_reg <= wr_en_n_o ? 0 : we_cnt_reg + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wr_qual_a: assert property (
    !wr_en_n_o |-> out_en_n_o && !chip_en_n_o && data_lines_oe_o)
    else $error("write strobe without its qualifiers");
  rd_free_a: assert property (
    !out_en_n_o |-> wr_en_n_o && !chip_en_n_o && !data_lines_oe_o)
    else $error("read while driving the data lines");
  wr_pulse_a: assert property (
    $rose(wr_en_n_o) |-> we_cnt_reg == fci_pkg::PULSE_CYC)
    else $error("write pulse length wrong");
  wr_setup_a: assert property (
    $fell(wr_en_n_o) |-> $stable(byte_address_o) && $stable(data_lines_o))
    else $error("address or data moved as write began");
  wr_latch_a: assert property (
    $rose(wr_en_n_o) |-> $stable(data_lines_o) ##1 $stable(data_lines_o))
    else $error("data moved around the latching edge");
  take_a: assert property (
    ready_o && req_i |=> !ready_o ##[28:400] done_o)
    else $error("request not taken or not finished in time");
  done_one_a: assert property (
    $rose(done_o) |=> !done_o)
    else $error("done longer than one cycle");
  byp_on_a: assert property (
    $rose(bypass_o) |-> data_lines_o == fci_pkg::CMD_BYPASS)
    else $error("bypass flag set without bypass command");
  byp_off_a: assert property (
    $fell(bypass_o) |-> data_lines_o == fci_pkg::CMD_BYP_EXIT2)
    else $error("bypass flag cleared without exit command");
endmodule
bind fci_host fci_host_chk #(.ABORT_CYC(ABORT_CYC)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .ready_o(ready_o),
  .done_o(done_o), .byte_address_o(byte_address_o),
  .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
  .chip_en_n_o(chip_en_n_o), .out_en_n_o(out_en_n_o),
  .wr_en_n_o(wr_en_n_o), .bypass_o(bypass_o));

// *** sim/fci_flash_model.sv ***
// Purpose: Behavioural byte-wide flash command interface
// Assumes: Program and erase finish at once, so no status word
// Notes:   Released lines show the inverse of the last read value
`timescale 1ns/1ps
module fci_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A, // Arbitrary value
  parameter logic [2:0] PROT_BLK   = 3'h5
) (
  input  wire logic [18:0] byte_address_i,
  input  wire logic [7:0]  data_lines_i,
  input  wire logic        chip_en_n_i,
  input  wire logic        out_en_n_i,
  input  wire logic        wr_en_n_i,
  input  wire logic        identification_level_i,
  output logic      [7:0]  data_lines_o
);
  logic [7:0]  mem [0:524287];
  logic [7:0]  hold_reg = 8'hFF;
  logic        id_reg = 1'b0;
  int          phase = 0;
  logic [10:0] a;
  logic [7:0]  d;
  logic [7:0]  rv;
  wire         rd = !chip_en_n_i && !out_en_n_i;
  // Latch when enable or strobe rises, whichever comes first
  wire         wr_act = !chip_en_n_i && !wr_en_n_i;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  task automatic ers(input int b);
    for (int i = 0; i < 524288; i++)
      if (i[18:16] != PROT_BLK && (b < 0 || i[18:16] == b[2:0]))
        mem[i] = 8'hFF;
  endtask
  task automatic prg();
    if (byte_address_i[18:16] != PROT_BLK)
      mem[byte_address_i] = mem[byte_address_i] & d;
  endtask
  assign rv = !(id_reg || identification_level_i) ?
    mem[byte_address_i] :
    byte_address_i[1:0] == 2'h0 ? MAKER_CODE :
    byte_address_i[1:0] == 2'h1 ? PART_CODE :
    {7'h00, byte_address_i[18:16] == PROT_BLK};
  // Refreshed on every read, even when the value repeats
  always @(rv or rd) if (rd) hold_reg = ~rv;
  assign data_lines_o = rd ? rv : hold_reg;
  always @(negedge wr_act) begin
    a = byte_address_i[10:0];
    d = data_lines_i;
    case (phase)
      1: phase = (a == 11'h2AA && d == 8'h55) ? 2 : 0;
      2: begin
        id_reg = a == 11'h555 && d == 8'h90;
        phase = a != 11'h555 ? 0 : d == 8'hA0 ? 6 : d == 8'h20 ? 7 :
                d == 8'h80 ? 3 : 0;
      end
      3: phase = (a == 11'h555 && d == 8'hAA) ? 4 : 0;
      4: phase = (a == 11'h2AA && d == 8'h55) ? 5 : 0;
      5, 10: begin
        if (phase == 5 && a == 11'h555 && d == 8'h10) ers(-1);
        if (d == 8'h30) ers(int'(byte_address_i[18:16]));
        if (phase == 10 && d == 8'hF0) mem[byte_address_i] = 'x;
        phase = d == 8'h30 ? 10 : 0;
      end
      6, 8: begin
        prg();
        phase = phase == 8 ? 7 : 0;
      end
      7: phase = d == 8'hA0 ? 8 : d == 8'h90 ? 9 : 7;
      9: phase = d == 8'h00 ? 0 : 7;
      default: begin
        if (d == 8'hF0) id_reg = 1'b0;
        phase = (a == 11'h555 && d == 8'hAA) ? 1 : 0;
      end
    endcase
  end
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the flash host controller
// Assumes: Abort wait shortened to 5 cycles
// Notes:   Driver queues expected read data, monitor compares at done
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] MK = 8'h3C;
  localparam logic [7:0] PT = 8'h5A;
  localparam logic [2:0] PB = 3'h5;
  logic        clk_i, arst_n_i, req_i, id_level_i;
  logic [3:0]  op_i;
  logic [18:0] addr_i, byte_address_o, ta, qa, za;
  logic [7:0]  data_i, rdata_o, dq_o, dq_m, dq, d1, d2;
  logic        ready_o, done_o, dq_oe, ce_n, oe_n, we_n, idl, bypass_o;
  logic [8:0]  exp_q[$];
  logic [8:0]  e;
  int          miscompares, n_tests;
  assign dq = dq_oe ? dq_o : dq_m;
  fci_host #(.ABORT_CYC(5)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .data_i(data_i), .id_level_i(id_level_i),
    .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .byte_address_o(byte_address_o), .data_lines_o(dq_o),
    .data_lines_oe_o(dq_oe), .data_lines_i(dq), .chip_en_n_o(ce_n),
    .out_en_n_o(oe_n), .wr_en_n_o(we_n), .identification_level_o(idl),
    .bypass_o(bypass_o));
  fci_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT), .PROT_BLK(PB)) u_fl (
    .byte_address_i(byte_address_o), .data_lines_i(dq),
    .chip_en_n_i(ce_n), .out_en_n_i(oe_n), .wr_en_n_i(we_n),
    .identification_level_i(idl), .data_lines_o(dq_m));
  task chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task op(input logic [3:0] o, input logic [18:0] a, input logic [7:0] d,
          input logic [8:0] x);
    @(negedge clk_i);
    while (ready_o !== 1'b1) @(negedge clk_i);
    op_i = o;
    addr_i = a;
    data_i = d;
    req_i = 1'b1;
    exp_q.push_back(x);
    @(negedge clk_i);
    req_i = 1'b0;
    repeat (1000) begin
      if (done_o === 1'b1) break;
      @(negedge clk_i);
    end
    chk("done", {7'h00, done_o}, 8'h01);
    @(negedge clk_i);
  endtask
  task wr(input logic [3:0] o, input logic [18:0] a, input logic [7:0] d);
    op(o, a, d, 9'h000);
  endtask
  task rd(input logic [18:0] a, input logic [7:0] x);
    op(fci_pkg::OP_READ, a, 8'h00, {1'b1, x});
  endtask
  task summarize();
    chk("pending", 8'(exp_q.size()), 8'h00);
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Only reads carry a note worth comparing; writes pop a blank one
  // Sampled mid-cycle, where done and read data have settled
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious done", 8'h01, 8'h00);
      else begin
        e = exp_q.pop_front();
        if (e[8]) chk("rdata", rdata_o, e[7:0]);
      end
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
  initial begin
    {arst_n_i, req_i, op_i, addr_i, data_i, id_level_i} = '0;
    void'($urandom(59));
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    ta = {3'h1, 16'($urandom)};
    qa = {PB, 16'($urandom)};
    za = {3'h2, 16'($urandom)};
    wr(fci_pkg::OP_PROGRAM, ta, d1);
    rd(ta, d1);
    wr(fci_pkg::OP_PROGRAM, ta, d2);
    rd(ta, d1 & d2);
    wr(fci_pkg::OP_PROGRAM, qa, d1);
    rd(qa, 8'hFF);
    $display("program test done");
    wr(fci_pkg::OP_IDENT, 19'h00000, 8'h00);
    rd({17'($urandom), 2'h0}, MK);
    rd({17'($urandom), 2'h1}, PT);
    rd({PB, 14'($urandom), 2'h2}, 8'h01);
    rd({3'h1, 14'($urandom), 2'h2}, 8'h00);
    wr(fci_pkg::OP_RESET3, 19'h00000, 8'h00);
    rd(ta, d1 & d2);
    $display("identification test done");
    wr(fci_pkg::OP_BYPASS, 19'h00000, 8'h00);
    chk("bypass", {7'h00, bypass_o}, 8'h01);
    wr(fci_pkg::OP_BYP_PROG, za, d1);
    rd(za, d1);
    wr(fci_pkg::OP_RESET1, 19'h00000, 8'h00);
    chk("bypass", {7'h00, bypass_o}, 8'h01);
    wr(fci_pkg::OP_BYP_EXIT, 19'h00000, 8'h00);
    chk("bypass", {7'h00, bypass_o}, 8'h00);
    $display("bypass test done");
    wr(fci_pkg::OP_BLK_ERS, ta, 8'h00);
    wr(fci_pkg::OP_BLK_ADD, za, 8'h00);
    rd(ta, 8'hFF);
    rd(za, 8'hFF);
    wr(fci_pkg::OP_SUSPEND, za, 8'h00);
    wr(fci_pkg::OP_RESUME, ta, 8'h00);
    wr(fci_pkg::OP_PROGRAM, ta, d2);
    rd(ta, d2);
    wr(fci_pkg::OP_CHIP_ERS, 19'h00000, 8'h00);
    rd(ta, 8'hFF);
    $display("erase test done");
    id_level_i = 1'b1;
    rd({17'($urandom), 2'h1}, PT);
    id_level_i = 1'b0;
    rd(ta, 8'hFF);
    $display("identification level test done");
    summarize();
  end
endmodule
